// >>> spr_status_readback.sv
// two-wire slave answering the two status read-back commands
module spr_status_readback
	import spr_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic fuse_addr_bit3,
	input wire logic fuse_addr_bit2,
	input wire logic fuse_addr_bit1,
	input wire logic fuse_addr_bit0,
	input wire logic hardwired_addr_bit,
	input wire logic [3:0] runCurrent,
	input wire logic [3:0] holdCurrent,
	input wire logic [3:0] maxVelocity,
	input wire logic [3:0] minVelocity,
	input wire logic accel_shape,
	input wire logic [1:0] step_resolution,
	input wire logic direction,
	input wire logic [3:0] acceleration,
	input wire logic logic_supply_reset_flag,
	input wire logic lost_step_flag,
	input wire logic electrical_defect,
	input wire logic undervoltage_flag,
	input wire logic thermal_shutdown,
	input wire logic thermal_warning,
	input wire logic [1:0] thermalInfo,
	input wire logic [2:0] motionState,
	input wire logic ext_switch_state,
	input wire logic coil_a_overcurrent,
	input wire logic coil_b_overcurrent,
	input wire logic pump_failure,
	input wire logic [15:0] actual_position,
	input wire logic [15:0] target_position,
	input wire logic [10:0] secure_position,
	output logic busy
);
	// pins pass two flops; the second stage and its one-cycle-delayed copy feed logic
	logic [1:0] sclSync_r, sdaSync_r;
	logic sclD_r, sdaD_r;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sclSync_r <= 2'h3;
			sdaSync_r <= 2'h3;
			sclD_r <= 1'b1;
			sdaD_r <= 1'b1;
		end else begin
			sclSync_r <= {sclSync_r[0], sclIn};
			sdaSync_r <= {sdaSync_r[0], sdaIn};
			sclD_r <= sclSync_r[1];
			sdaD_r <= sdaSync_r[1];
		end
	end
	wire logic scl = sclSync_r[1];
	wire logic sda = sdaSync_r[1];
	wire logic sclRise = scl && !sclD_r;
	wire logic sclFall = !scl && sclD_r;
	wire logic startCond = scl && sclD_r && !sda && sdaD_r;
	wire logic stopCond = scl && sclD_r && sda && !sdaD_r;

	wire logic [6:0] ownAddr = {ADDR_FIXED, fuse_addr_bit3, fuse_addr_bit2, fuse_addr_bit1, fuse_addr_bit0,
		hardwired_addr_bit};

	spr_state_t state_r, state_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [2:0] bitCnt_r, bitCnt_nxt;
	logic [3:0] byteIdx_r, byteIdx_nxt;
	logic [7:0] cmd_r, cmd_nxt;
	logic readDir_r, readDir_nxt;
	logic sdaOut_r, sdaOut_nxt;
	logic sdaOe_r, sdaOe_nxt;
	logic [55:0] snap_r, snap_nxt;

	// frame image built from live inputs; taken once per response
	function automatic logic [55:0] build_frame(input logic [7:0] c);
		logic [15:0] pos;
		pos = actual_position;
		if (step_resolution == HALF_STEP)
			pos[2:0] = 3'h0;
		if (c == CMD_POSITION_STATUS)
			build_frame = {pos, target_position, secure_position[7:0],
				SEC_PAD, secure_position[10:8], NA_BYTE};
		else
			build_frame = {runCurrent, holdCurrent, maxVelocity, minVelocity,
				accel_shape, step_resolution, direction, acceleration,
				logic_supply_reset_flag, lost_step_flag, electrical_defect, undervoltage_flag,
				thermal_shutdown, thermal_warning, thermalInfo,
				motionState, ext_switch_state, coil_a_overcurrent, coil_b_overcurrent, 1'b1, pump_failure,
				NA_BYTE, NA_BYTE};
	endfunction

	// byte 1 echoes the address; bytes 2-8 come from the snapshot
	function automatic logic [7:0] tx_byte(input logic [3:0] idx, input logic [55:0] s);
		if (idx == 4'h0)
			tx_byte = {3'h0, ownAddr[4:0]};
		else
			tx_byte = s[55 - 8 * (int'(idx) - 1) -: 8];
	endfunction

	always_comb begin
		state_nxt = state_r;
		shift_nxt = shift_r;
		bitCnt_nxt = bitCnt_r;
		byteIdx_nxt = byteIdx_r;
		cmd_nxt = cmd_r;
		readDir_nxt = readDir_r;
		sdaOut_nxt = sdaOut_r;
		sdaOe_nxt = sdaOe_r;
		snap_nxt = snap_r;
		if (startCond) begin
			state_nxt = SPR_ADDR;
			bitCnt_nxt = 3'h0;
			// an empty shifter keeps the fall right after the start from acking a stale byte
			shift_nxt = 8'h00;
			sdaOe_nxt = 1'b0;
		end else if (stopCond) begin
			state_nxt = SPR_IDLE;
			sdaOe_nxt = 1'b0;
		end else begin
			case (state_r)
				SPR_ADDR, SPR_RX: begin
					if (sclRise) begin
						shift_nxt = {shift_r[6:0], sda};
						bitCnt_nxt = bitCnt_r + 3'h1;
					end
					if (sclFall && bitCnt_r == 3'h0 && (shift_r != 8'h00 || state_r == SPR_RX)) begin
						if (state_r == SPR_ADDR && shift_r[7:1] != ownAddr) begin
							state_nxt = SPR_SKIP;
						end else begin
							if (state_r == SPR_ADDR)
								readDir_nxt = shift_r[0];
							else
								cmd_nxt = shift_r;
							sdaOut_nxt = 1'b0;
							sdaOe_nxt = 1'b1;
							state_nxt = SPR_ACK;
						end
					end
				end
				SPR_ACK: begin
					if (sclFall) begin
						if (readDir_r) begin
							// snapshot keeps one frame coherent while live values move
							snap_nxt = build_frame(cmd_r);
							byteIdx_nxt = 4'h0;
							shift_nxt = tx_byte(4'h0, snap_r);
							sdaOut_nxt = shift_nxt[7];
							sdaOe_nxt = 1'b1;
							bitCnt_nxt = 3'h0;
							state_nxt = SPR_TX;
						end else begin
							sdaOe_nxt = 1'b0;
							bitCnt_nxt = 3'h0;
							state_nxt = SPR_RX;
						end
					end
				end
				SPR_TX: begin
					if (sclFall) begin
						bitCnt_nxt = bitCnt_r + 3'h1;
						shift_nxt = {shift_r[6:0], 1'b1};
						if (bitCnt_r == 3'h7) begin
							sdaOe_nxt = 1'b0;
							state_nxt = SPR_TXACK;
						end else begin
							sdaOut_nxt = shift_r[6];
						end
					end
				end
				SPR_TXACK: begin
					if (sclRise && sda) begin
						state_nxt = SPR_SKIP;
					end else if (sclFall) begin
						byteIdx_nxt = (byteIdx_r == LAST_BYTE - 4'h1) ? byteIdx_r : byteIdx_r + 4'h1;
						shift_nxt = (byteIdx_r == LAST_BYTE - 4'h1) ? NA_BYTE : tx_byte(byteIdx_r + 4'h1, snap_r);
						sdaOut_nxt = shift_nxt[7];
						sdaOe_nxt = 1'b1;
						bitCnt_nxt = 3'h0;
						state_nxt = SPR_TX;
					end
				end
				default: begin
					sdaOe_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= SPR_IDLE;
			shift_r <= 8'h00;
			bitCnt_r <= 3'h0;
			byteIdx_r <= 4'h0;
			cmd_r <= 8'h00;
			readDir_r <= 1'b0;
			sdaOut_r <= 1'b1;
			sdaOe_r <= 1'b0;
			snap_r <= '1;
			busy <= 1'b0;
		end else begin
			state_r <= state_nxt;
			shift_r <= shift_nxt;
			bitCnt_r <= bitCnt_nxt;
			byteIdx_r <= byteIdx_nxt;
			cmd_r <= cmd_nxt;
			readDir_r <= readDir_nxt;
			sdaOut_r <= sdaOut_nxt;
			sdaOe_r <= sdaOe_nxt;
			snap_r <= snap_nxt;
			busy <= (state_nxt != SPR_IDLE);
		end
	end
	assign sdaOut = sdaOut_r;
	assign sdaOe = sdaOe_r;

	// live frame image kept apart from the snapshot path so the capture can be checked
	logic [55:0] liveFrame;
	always_comb begin
		liveFrame = build_frame(cmd_r);
	end

	// the fall that ends the read-address ack opens every response
	sequence s_read_ack_fall;
		state_r == SPR_ACK && readDir_r && sclFall;
	endsequence

	a_ack_drives_low: assert property (@(posedge core_clk) disable iff (!rst_b)
		state_r == SPR_ACK |-> sdaOe_r && !sdaOut_r) else $error("ack not driven low");
	a_txack_released: assert property (@(posedge core_clk) disable iff (!rst_b)
		state_r == SPR_TXACK |-> !sdaOe_r) else $error("sda held during master ack");
	a_stop_idles: assert property (@(posedge core_clk) disable iff (!rst_b)
		stopCond |=> state_r == SPR_IDLE && !sdaOe_r) else $error("stop not honoured");
	a_snap_taken: assert property (@(posedge core_clk) disable iff (!rst_b)
		s_read_ack_fall |=> snap_r == $past(liveFrame)) else $error("snapshot missed");
	a_half_step_pos: assert property (@(posedge core_clk) disable iff (!rst_b)
		s_read_ack_fall ##0 (cmd_r == CMD_POSITION_STATUS && step_resolution == HALF_STEP)
		|=> snap_r[42:40] == 3'h0) else $error("half step low bits not cleared");
	a_na_ones: assert property (@(posedge core_clk) disable iff (!rst_b)
		state_r == SPR_TX && byteIdx_r == LAST_BYTE - 4'h1 && sdaOe_r |-> sdaOut_r) else $error("n/a byte not ones");
endmodule

// >>> spr_pkg.sv
// constants for the status and position read-back slave
// Behaviour
// - not-applicable response bits are driven as ones
// - byte 0 address+read, byte 1 echoed address
// - status read returns settings and all flags
// - bytes 2-4: currents, velocities, motion settings
// - bytes 5-6 diagnostic flags, bytes 7-8 ones
// - actual position low three bits zero in half-step
// - position read: actual, target, secure, ones
// - command 0x81 status, 0xFC position
// - write command datagram then read datagram, NACK ends
// - seven-bit address: 11, fuse bits, hardwired bit
package spr_pkg;
	localparam logic [7:0] CMD_FULL_STATUS = 8'h81;
	localparam logic [7:0] CMD_POSITION_STATUS = 8'hFC;
	localparam logic [1:0] ADDR_FIXED = 2'h3;
	localparam logic [1:0] HALF_STEP = 2'h0;
	localparam logic [7:0] NA_BYTE = 8'hFF;
	localparam logic [4:0] SEC_PAD = 5'h1F;
	localparam int RESP_BYTES = 9;
	localparam logic [3:0] LAST_BYTE = 4'h8;
	typedef enum logic [2:0] {SPR_IDLE, SPR_ADDR, SPR_ACK, SPR_RX, SPR_TX, SPR_TXACK, SPR_SKIP} spr_state_t;
endpackage

// >>> spr_host_model.sv
// two-wire bus master model for the read-back slave
module spr_host_model (
	input wire logic core_clk,
	input wire logic sdaWire,
	output logic scl,
	output logic sdaM
);
	timeunit 1ns;
	timeprecision 1ps;
	// both lines idle high; the link clock only runs inside frames
	initial begin
		scl = 1'b1;
		sdaM = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// 32 core clocks per bit gives a 160 ns link clock
	task automatic xbit(input logic b, output logic r);
		sdaM <= b;
		tick(8);
		scl <= 1'b1;
		tick(8);
		r = sdaWire;
		tick(8);
		scl <= 1'b0;
		tick(8);
	endtask
	task automatic xbyte(input logic [7:0] v, output logic [7:0] r);
		for (int i = 7; i >= 0; i--)
			xbit(v[i], r[i]);
	endtask
	task automatic start();
		sdaM <= 1'b0;
		tick(8);
		scl <= 1'b0;
		tick(8);
	endtask
	task automatic stop();
		sdaM <= 1'b0;
		tick(8);
		scl <= 1'b1;
		tick(8);
		sdaM <= 1'b1;
		tick(16);
	endtask
	// command goes in a write datagram, answer comes in a separate read datagram
	task automatic readFrame(input logic [6:0] addr, input logic [7:0] cmd, output logic [2:0] acks,
		output logic [63:0] resp);
		logic [7:0] b;
		start();
		xbyte({addr, 1'b0}, b);
		xbit(1'b1, acks[2]);
		xbyte(cmd, b);
		xbit(1'b1, acks[1]);
		stop();
		start();
		xbyte({addr, 1'b1}, b);
		xbit(1'b1, acks[0]);
		for (int k = 0; k < 8; k++) begin
			xbyte(8'hFF, b);
			resp = {resp[55:0], b}; // stored as read, no meaning given to unused bits
			xbit(k == 7, b[0]);
		end
		stop();
	endtask
endmodule

// >>> testbench.sv
// self-checking bench for the status read-back slave
module testbench
	import spr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rst_b, sclIn, sdaM, sdaOut, sdaOe, busy, fuse_addr_bit3, fuse_addr_bit2, fuse_addr_bit1, fuse_addr_bit0;
	logic hardwired_addr_bit, accel_shape, direction, logic_supply_reset_flag, lost_step_flag, electrical_defect;
	logic undervoltage_flag, thermal_shutdown, thermal_warning, ext_switch_state, coil_a_overcurrent;
	logic coil_b_overcurrent, pump_failure;
	logic [3:0] runCurrent, holdCurrent, maxVelocity, minVelocity, acceleration;
	logic [1:0] step_resolution, thermalInfo;
	logic [2:0] motionState, acks;
	logic [15:0] actual_position, target_position;
	logic [10:0] secure_position;
	logic [63:0] resp, expd;
	logic [95:0] rnd;
	int seed = 32'h5F2106E9;
	int fails = 0;
	int totalChecks = 0;
	int cycles = 0;
	logic busySeen = 1'b0;
	// a released line follows the master's sdaM level
	wire sdaIn = sdaOe ? sdaOut : sdaM;
	always #2.5 core_clk = ~core_clk;
	spr_status_readback u_dut (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.sclIn(sclIn),
		.sdaIn(sdaIn),
		.sdaOut(sdaOut),
		.sdaOe(sdaOe),
		.fuse_addr_bit3(fuse_addr_bit3),
		.fuse_addr_bit2(fuse_addr_bit2),
		.fuse_addr_bit1(fuse_addr_bit1),
		.fuse_addr_bit0(fuse_addr_bit0),
		.hardwired_addr_bit(hardwired_addr_bit),
		.runCurrent(runCurrent),
		.holdCurrent(holdCurrent),
		.maxVelocity(maxVelocity),
		.minVelocity(minVelocity),
		.accel_shape(accel_shape),
		.step_resolution(step_resolution),
		.direction(direction),
		.acceleration(acceleration),
		.logic_supply_reset_flag(logic_supply_reset_flag),
		.lost_step_flag(lost_step_flag),
		.electrical_defect(electrical_defect),
		.undervoltage_flag(undervoltage_flag),
		.thermal_shutdown(thermal_shutdown),
		.thermal_warning(thermal_warning),
		.thermalInfo(thermalInfo),
		.motionState(motionState),
		.ext_switch_state(ext_switch_state),
		.coil_a_overcurrent(coil_a_overcurrent),
		.coil_b_overcurrent(coil_b_overcurrent),
		.pump_failure(pump_failure),
		.actual_position(actual_position),
		.target_position(target_position),
		.secure_position(secure_position),
		.busy(busy)
	);
	spr_host_model u_host (.core_clk(core_clk), .sdaWire(sdaIn), .scl(sclIn), .sdaM(sdaM));
	function automatic logic [7:0] echo();
		return {3'h0, fuse_addr_bit3, fuse_addr_bit2, fuse_addr_bit1, fuse_addr_bit0, hardwired_addr_bit};
	endfunction
	function automatic logic [6:0] addr();
		return {ADDR_FIXED, fuse_addr_bit3, fuse_addr_bit2, fuse_addr_bit1, fuse_addr_bit0, hardwired_addr_bit};
	endfunction
	function automatic logic [63:0] expFull();
		return {echo(), runCurrent, holdCurrent, maxVelocity, minVelocity, accel_shape, step_resolution, direction,
			acceleration, logic_supply_reset_flag, lost_step_flag, electrical_defect, undervoltage_flag,
			thermal_shutdown, thermal_warning, thermalInfo, motionState, ext_switch_state, coil_a_overcurrent,
			coil_b_overcurrent, 1'b1, pump_failure, NA_BYTE, NA_BYTE};
	endfunction
	function automatic logic [63:0] expPos();
		logic [15:0] act;
		act = (step_resolution == HALF_STEP) ? {actual_position[15:3], 3'h0} : actual_position;
		return {echo(), act, target_position, secure_position[7:0], SEC_PAD, secure_position[10:8], NA_BYTE};
	endfunction
	task automatic checkResp(input logic [63:0] got, input logic [63:0] exp);
		totalChecks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic checkFlag(input logic [2:0] got, input logic [2:0] exp);
		checkResp({61'h0, got}, {61'h0, exp});
	endtask
	// step resolution sits lowest so the half-step corner can be forced without a second assignment
	task automatic setInputs(input logic half);
		rnd = {$random(seed), $random(seed), $random(seed)};
		if (half)
			rnd[1:0] = HALF_STEP;
		{fuse_addr_bit3, fuse_addr_bit2, fuse_addr_bit1, fuse_addr_bit0, hardwired_addr_bit, runCurrent, holdCurrent,
			maxVelocity, minVelocity, accel_shape, direction, acceleration, logic_supply_reset_flag, lost_step_flag,
			electrical_defect, undervoltage_flag, thermal_shutdown, thermal_warning, thermalInfo, motionState,
			ext_switch_state, coil_a_overcurrent, coil_b_overcurrent, pump_failure, actual_position,
			target_position, secure_position, step_resolution} <= rnd[86:0];
	endtask
	task automatic finishTest();
		$display("checks %0d mismatches %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// nine frames of about 3300 cycles each
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (busy === 1'b1)
			busySeen <= 1'b1;
		if (cycles == 60000) begin
			fails++;
			finishTest();
		end
	end
	initial begin
		rst_b = 1'b0;
		setInputs(1'b0);
		repeat (6) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		for (int i = 0; i < 9; i++) begin
			setInputs(i < 2);
			@(posedge core_clk);
			expd = i[0] ? expPos() : expFull();
			fork
				u_host.readFrame(i == 8 ? addr() ^ 7'h02 : addr(), i[0] ? CMD_POSITION_STATUS : CMD_FULL_STATUS,
					acks, resp);
				begin
					// live values move mid-answer; the frame must still show the snapshot
					repeat (1500) @(posedge core_clk);
					if (i > 1 && i < 8)
						setInputs(1'b0);
				end
			join
			if (i == 8) begin
				checkFlag(acks, 3'h7);
				checkResp(resp, 64'hFFFFFFFFFFFFFFFF);
			end else begin
				checkFlag(acks, 3'h0);
				checkResp(resp, expd);
			end
			checkFlag({2'h0, busy}, 3'h0);
		end
		checkFlag({2'h0, busySeen}, 3'h1);
		finishTest();
	end
endmodule
